// *** hdl/mps_pkg.sv ***
// package for the module power-state signal block
`default_nettype none
package mps_pkg;
    localparam int CLK_HZ = 40000000;
    localparam int MIN_PULSE_MS = 16;
    // least pulse in whole cycles; the kHz divide rounds down
    localparam int MIN_PULSE_CYC = (CLK_HZ / 1000) * MIN_PULSE_MS;
    localparam int RESET_HOLD_CYC = 16;
    localparam logic RESET_LEVEL_N = 1'b0;

    typedef enum logic [3:0] {
        MPS_SOFT_OFF = 4'b0001,
        MPS_RUN = 4'b0010,
        MPS_WARN = 4'b0100,
        MPS_SUSPEND = 4'b1000
    } mps_state_t;

    // raw carrier inputs, all active low except supply_good
    typedef struct packed {
        logic power_button_n;
        logic reset_button_n;
        logic supply_good;
        logic pcie_wake_n;
        logic general_wake_n;
        logic battery_low_n;
        logic lid_n;
        logic sleep_button_n;
        logic over_temp_in_n;
        logic mgmt_bus_alert_n;
    } mps_pins_t;

    // one-cycle events and levels reported to the system
    typedef struct packed {
        logic power_press;
        logic reset_press;
        logic lid_change;
        logic sleep_press;
        logic wake;
        logic battery_low;
        logic over_temp;
        logic mgmt_alert;
        logic mgmt_smi;
    } mps_events_t;
endpackage
`default_nettype wire

// *** hdl/mps_power_state.sv ***
// power and system management sequencer at the carrier connector
// What this block does
// - power button falling edge held 16 ms leaves soft-off state
// - reset button is edge-triggered; a held low does not hold reset
// - carrier reset driven low by button, supply bad, 12 V low, watchdog, software
// - supply_good low means power not good
// - suspend warning asserted before entering suspend
// - suspend_to_ram_n held low while suspended
// - suspend-to-disk output unsupported, held inactive high
// - soft_off_n asserted whenever in soft-off state
// - two active-low wake inputs, pcie and general, wake the system
// - battery_low_n low reports a low-battery event
// - lid input reported after being low 16 ms
// - sleep button held 16 ms enters sleep or wakes
// - fast shutdown trigger pin ignored
// - over_temp_in_n low reports over-temperature
// - thermal trip output driven low once processor is in thermal shutdown
// - management-bus alert raises interrupt or wakes system
`default_nettype none
module mps_power_state #(
    parameter int PULSE_CYC = mps_pkg::MIN_PULSE_CYC,
    parameter int HOLD_CYC = mps_pkg::RESET_HOLD_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire mps_pkg::mps_pins_t pins,
    input wire logic twelve_volt_low,
    input wire logic watchdog_timeout,
    input wire logic software_reset,
    input wire logic cpu_thermal_shutdown,
    input wire logic fast_shutdown_trigger,
    input wire logic alert_wakes,
    output logic carrier_reset_out_n,
    output logic suspend_warning_n,
    output logic suspend_to_ram_n,
    output logic suspend_to_disk_n,
    output logic soft_off_n,
    output logic thermal_trip_out_n,
    output mps_pkg::mps_events_t events,
    output mps_pkg::mps_state_t power_state
);
    localparam int NPIN = $bits(mps_pkg::mps_pins_t);
    localparam int CW = $clog2(PULSE_CYC + 1);
    localparam int HW = $clog2(HOLD_CYC + 1);

    // pins idle high (pulled up); reset value avoids a spurious edge
    localparam logic [NPIN-1:0] IDLE = '1;

    logic [NPIN-1:0] meta_r;
    logic [NPIN-1:0] sync_r;
    logic [NPIN-1:0] sync_d_r;
    mps_pkg::mps_pins_t s;

    // two-flop synchroniser per pin
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_r <= IDLE;
            sync_r <= IDLE;
            sync_d_r <= IDLE;
        end else begin
            meta_r <= pins;
            sync_r <= meta_r;
            sync_d_r <= sync_r;
        end
    end
    assign s = mps_pkg::mps_pins_t'(sync_r);

    // qualifiers for the four inputs that need a 16 ms low
    localparam int NQ = 4;
    wire [NQ-1:0] q_in = {s.power_button_n, s.reset_button_n, s.lid_n, s.sleep_button_n};
    logic [NQ-1:0] q_fire;
    logic [NQ-1:0] q_lid_level;
    genvar gi;
    generate
        for (gi = 0; gi < NQ; gi++) begin : g_qual
            logic [CW-1:0] cnt_r;
            logic done_r;
            wire low = ~q_in[gi];
            wire at_min = (cnt_r == CW'(PULSE_CYC - 1));
            // one pulse per press: the event fires once the low has lasted long enough
            always_ff @(posedge core_clk) begin
                if (rst || !low) begin
                    cnt_r <= '0;
                    done_r <= 1'b0;
                end else if (!done_r) begin
                    cnt_r <= at_min ? cnt_r : cnt_r + CW'(1);
                    done_r <= at_min;
                end
            end
            assign q_fire[gi] = low && at_min && !done_r;
            assign q_lid_level[gi] = done_r;
        end
    endgenerate

    wire power_press = q_fire[3];
    wire reset_press = q_fire[2];
    wire sleep_press = q_fire[0];
    wire supply_bad = ~s.supply_good;
    wire wake_req = ~s.pcie_wake_n | ~s.general_wake_n;
    wire alert_low = ~s.mgmt_bus_alert_n;
    wire alert_edge = alert_low & sync_d_r[0];

    // fast shutdown trigger is not connected on this module
    wire unused_ok = fast_shutdown_trigger;

    // power-state machine
    mps_pkg::mps_state_t state_r;
    mps_pkg::mps_state_t state_nxt;
    wire resume = wake_req | power_press | sleep_press | (alert_edge & alert_wakes);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            mps_pkg::MPS_SOFT_OFF: begin
                if (power_press) begin
                    state_nxt = mps_pkg::MPS_RUN;
                end
            end
            mps_pkg::MPS_RUN: begin
                if (sleep_press) begin
                    state_nxt = mps_pkg::MPS_WARN;
                end else if (power_press) begin
                    state_nxt = mps_pkg::MPS_SOFT_OFF;
                end
            end
            // warning cycle always precedes suspend
            mps_pkg::MPS_WARN: state_nxt = mps_pkg::MPS_SUSPEND;
            mps_pkg::MPS_SUSPEND: begin
                if (resume) begin
                    state_nxt = mps_pkg::MPS_RUN;
                end
            end
            default: state_nxt = mps_pkg::MPS_SOFT_OFF;
        endcase
        // thermal shutdown forces soft-off
        if (cpu_thermal_shutdown) begin
            state_nxt = mps_pkg::MPS_SOFT_OFF;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= mps_pkg::MPS_SOFT_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // carrier reset: edge sources stretch a fixed hold, levels hold directly
    logic [HW-1:0] hold_r;
    wire rst_edge_src = reset_press | watchdog_timeout | software_reset;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hold_r <= '0;
        end else if (rst_edge_src) begin
            hold_r <= HW'(HOLD_CYC);
        end else if (hold_r != '0) begin
            hold_r <= hold_r - HW'(1);
        end
    end
    // a button kept low does not extend the hold
    wire reset_cause = (hold_r != '0) | supply_bad | twelve_volt_low;

    logic cb_rst_n_r;
    logic warn_n_r;
    logic s3_n_r;
    logic s5_n_r;
    logic trip_n_r;
    mps_pkg::mps_events_t ev_r;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cb_rst_n_r <= mps_pkg::RESET_LEVEL_N;
            warn_n_r <= 1'b1;
            s3_n_r <= 1'b0;
            s5_n_r <= 1'b0;
            trip_n_r <= 1'b1;
            ev_r <= '0;
        end else begin
            // reset also held while off
            cb_rst_n_r <= ~(reset_cause | (state_nxt == mps_pkg::MPS_SOFT_OFF));
            warn_n_r <= ~(state_nxt == mps_pkg::MPS_WARN
                          || state_nxt == mps_pkg::MPS_SUSPEND);
            s3_n_r <= ~(state_nxt == mps_pkg::MPS_SUSPEND
                        || state_nxt == mps_pkg::MPS_SOFT_OFF);
            s5_n_r <= ~(state_nxt == mps_pkg::MPS_SOFT_OFF);
            trip_n_r <= ~cpu_thermal_shutdown;
            ev_r.power_press <= power_press;
            ev_r.reset_press <= reset_press;
            ev_r.lid_change <= q_fire[1];
            ev_r.sleep_press <= sleep_press;
            ev_r.wake <= wake_req;
            ev_r.battery_low <= ~s.battery_low_n;
            ev_r.over_temp <= ~s.over_temp_in_n;
            ev_r.mgmt_alert <= alert_low;
            ev_r.mgmt_smi <= alert_edge & ~alert_wakes;
        end
    end

    assign carrier_reset_out_n = cb_rst_n_r;
    assign suspend_warning_n = warn_n_r;
    assign suspend_to_ram_n = s3_n_r;
    assign suspend_to_disk_n = 1'b1;
    assign soft_off_n = s5_n_r;
    assign thermal_trip_out_n = trip_n_r;
    assign events = ev_r;
    assign power_state = state_r;

    // ---- assertions ----
    a_off_wake_power: assert property (@(posedge core_clk) disable iff (rst)
        state_r == mps_pkg::MPS_SOFT_OFF && power_press && !cpu_thermal_shutdown
        |=> state_r == mps_pkg::MPS_RUN)
        else $error("power press did not leave soft-off");
    a_reset_hold_bounded: assert property (@(posedge core_clk) disable iff (rst)
        hold_r <= HW'(HOLD_CYC))
        else $error("reset hold overran");
    a_supply_bad_reset: assert property (@(posedge core_clk) disable iff (rst)
        supply_bad |=> !carrier_reset_out_n)
        else $error("supply bad did not reset carrier");
    sequence s_warn;
        state_r == mps_pkg::MPS_WARN && !suspend_warning_n;
    endsequence
    a_warn_before_susp: assert property (@(posedge core_clk) disable iff (rst)
        $rose(state_r == mps_pkg::MPS_SUSPEND) |-> $past(state_r) == mps_pkg::MPS_WARN)
        else $error("suspend without warning");
    a_warn_then_s3: assert property (@(posedge core_clk) disable iff (rst)
        s_warn |=> !suspend_to_ram_n)
        else $error("suspend_to_ram_n not low in suspend");
    a_s4_inactive: assert property (@(posedge core_clk) disable iff (rst)
        suspend_to_disk_n)
        else $error("suspend-to-disk driven");
    a_s5_tracks: assert property (@(posedge core_clk) disable iff (rst)
        (soft_off_n == 1'b0) == (state_r == mps_pkg::MPS_SOFT_OFF))
        else $error("soft-off output mismatch");
    a_trip_follows: assert property (@(posedge core_clk) disable iff (rst)
        cpu_thermal_shutdown |=> !thermal_trip_out_n)
        else $error("thermal trip not driven");

    // suspend and sleep steps are checked from named sequences so the guards stay in one place; soft-off steps are guarded inline
    sequence s_suspended;
        state_r == mps_pkg::MPS_SUSPEND;
    endsequence
    sequence s_susp_clean;
        state_r == mps_pkg::MPS_SUSPEND && !cpu_thermal_shutdown;
    endsequence
    sequence s_sleep_req;
        state_r == mps_pkg::MPS_RUN && sleep_press && !cpu_thermal_shutdown;
    endsequence
    a_off_stays_off: assert property (@(posedge core_clk) disable iff (rst)
        state_r == mps_pkg::MPS_SOFT_OFF && !power_press |=> state_r == mps_pkg::MPS_SOFT_OFF)
        else $error("soft-off left without a power press");
    a_press_once: assert property (@(posedge core_clk) disable iff (rst)
        q_fire[3] |=> !q_fire[3])
        else $error("power press fired twice");
    a_held_no_reset: assert property (@(posedge core_clk) disable iff (rst)
        hold_r == '0 && !rst_edge_src && !supply_bad && !twelve_volt_low
        && state_nxt != mps_pkg::MPS_SOFT_OFF |=> carrier_reset_out_n)
        else $error("carrier reset held without cause");
    a_edge_src_reset: assert property (@(posedge core_clk) disable iff (rst)
        rst_edge_src |-> ##2 !carrier_reset_out_n)
        else $error("reset request did not reset carrier");
    a_twelve_reset: assert property (@(posedge core_clk) disable iff (rst)
        twelve_volt_low |=> !carrier_reset_out_n)
        else $error("low 12 V did not reset carrier");
    a_warn_in_susp: assert property (@(posedge core_clk) disable iff (rst)
        s_suspended |-> !suspend_warning_n)
        else $error("suspend warning not held in suspend");
    a_ram_in_susp: assert property (@(posedge core_clk) disable iff (rst)
        s_suspended |-> !suspend_to_ram_n)
        else $error("suspend_to_ram_n high in suspend");
    a_power_off_out: assert property (@(posedge core_clk) disable iff (rst)
        state_r == mps_pkg::MPS_RUN && power_press && !sleep_press |=> !soft_off_n)
        else $error("soft-off output not asserted on power-off");
    a_wake_resume: assert property (@(posedge core_clk) disable iff (rst)
        s_susp_clean ##0 wake_req |=> state_r == mps_pkg::MPS_RUN)
        else $error("wake input did not resume");
    a_battery_level: assert property (@(posedge core_clk) disable iff (rst)
        !s.battery_low_n |=> events.battery_low)
        else $error("battery low not reported");
    a_lid_event: assert property (@(posedge core_clk) disable iff (rst)
        q_fire[1] |=> events.lid_change)
        else $error("lid change not reported");
    a_lid_latched: assert property (@(posedge core_clk) disable iff (rst)
        q_fire[1] |=> q_lid_level[1])
        else $error("lid qualifier did not latch");
    a_sleep_enter: assert property (@(posedge core_clk) disable iff (rst)
        s_sleep_req |=> state_r == mps_pkg::MPS_WARN)
        else $error("sleep press did not start suspend");
    a_over_temp_level: assert property (@(posedge core_clk) disable iff (rst)
        !s.over_temp_in_n |=> events.over_temp)
        else $error("over-temperature not reported");
    a_thermal_off: assert property (@(posedge core_clk) disable iff (rst)
        cpu_thermal_shutdown |=> state_r == mps_pkg::MPS_SOFT_OFF)
        else $error("thermal shutdown did not force soft-off");
    a_alert_smi: assert property (@(posedge core_clk) disable iff (rst)
        alert_edge && !alert_wakes |=> events.mgmt_smi)
        else $error("alert did not raise interrupt event");
    a_alert_wakes: assert property (@(posedge core_clk) disable iff (rst)
        s_susp_clean ##0 (alert_edge && alert_wakes) |=> state_r == mps_pkg::MPS_RUN)
        else $error("alert did not wake the system");
endmodule // mps_power_state
`default_nettype wire

// *** test/mps_carrier_model.sv ***
// carrier model: buttons, supply and wake sources behind pull-ups
`default_nettype none
module mps_carrier_model (
    input wire logic core_clk,
    input wire logic [9:0] low_mask,
    output mps_pkg::mps_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] mask_r = 10'h000;
    // released lines return to the pull-up level; supply_good idles high
    always @(posedge core_clk) begin
        mask_r <= low_mask;
    end
    assign pins = mps_pkg::mps_pins_t'(~mask_r);
endmodule // mps_carrier_model
`default_nettype wire

// *** test/mps_power_state_tb_top.sv ***
// self-checking bench for the power-state sequencer
`default_nettype none
module mps_power_state_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P = 8;
    localparam int H = 4;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] low_mask = 10'h000;
    logic [3:0] cause = 4'h0;
    logic cpu_thermal_shutdown = 1'b0;
    logic fast_shutdown_trigger = 1'b0;
    logic alert_wakes = 1'b0;
    mps_pkg::mps_pins_t pins;
    logic carrier_reset_out_n, suspend_warning_n, suspend_to_ram_n;
    logic suspend_to_disk_n, soft_off_n, thermal_trip_out_n;
    mps_pkg::mps_events_t events;
    mps_pkg::mps_state_t power_state, exp_st;
    int error_cnt = 0;
    int compares = 0;
    int evc [9] = '{default: 0};
    int src [4] = '{6, 5, 2, 0};
    int lo_cnt = 0;
    int bad_fall = 0;
    int s0;
    logic ram_q = 1'b1;
    logic warn_q = 1'b1;
    logic [31:0] rnd = 32'hdd01;

    mps_carrier_model mps_carrier_model_inst (
        .core_clk(core_clk),
        .low_mask(low_mask | {2'h0, cause[3], 7'h00}),
        .pins(pins)
    );
    mps_power_state #(.PULSE_CYC(P), .HOLD_CYC(H)) mps_power_state_inst (
        .core_clk(core_clk), .rst(rst), .pins(pins),
        .twelve_volt_low(cause[0]), .watchdog_timeout(cause[1]),
        .software_reset(cause[2]), .cpu_thermal_shutdown(cpu_thermal_shutdown),
        .fast_shutdown_trigger(fast_shutdown_trigger), .alert_wakes(alert_wakes),
        .carrier_reset_out_n(carrier_reset_out_n), .suspend_warning_n(suspend_warning_n),
        .suspend_to_ram_n(suspend_to_ram_n), .suspend_to_disk_n(suspend_to_disk_n),
        .soft_off_n(soft_off_n), .thermal_trip_out_n(thermal_trip_out_n),
        .events(events), .power_state(power_state)
    );

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    // event pulses are counted here so held presses can be seen to fire once
    always @(posedge core_clk) begin
        rnd <= xs(rnd);
        fast_shutdown_trigger <= rnd[0];
        ram_q <= suspend_to_ram_n;
        warn_q <= suspend_warning_n;
        if (!rst) begin
            for (int k = 0; k < 9; k++) evc[k] += (events[k] === 1'b1);
            lo_cnt += (carrier_reset_out_n === 1'b0);
            if (ram_q === 1'b1 && suspend_to_ram_n === 1'b0 && warn_q !== 1'b0
                && power_state === mps_pkg::MPS_SUSPEND) bad_fall++;
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // n below P only where a too-short press is meant to be ignored
    task automatic press(input int i, input int n);
        @(posedge core_clk);
        low_mask[i] <= 1'b1;
        repeat (n) @(posedge core_clk);
        low_mask[i] <= 1'b0;
        cyc(6);
    endtask

    task automatic chk_b(input string n, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic chk_n(input string n, input int e, input int g);
        compares++;
        if (g != e) begin
            error_cnt++;
            $display("ERROR %s expected %0d seen %0d", n, e, g);
        end
    endtask

    task automatic chk_st;
        compares++;
        if (power_state !== exp_st) begin
            error_cnt++;
            $display("ERROR power_state expected %h seen %h", exp_st, power_state);
        end
    endtask

    task automatic final_report;
        if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge core_clk);
        error_cnt++;
        final_report;
    end

    initial begin
        exp_st = mps_pkg::MPS_SOFT_OFF;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        cyc(3);
        chk_st();
        chk_b("soft_off_n", 1'b0, soft_off_n);
        chk_b("suspend_to_disk_n", 1'b1, suspend_to_disk_n);
        press(9, P - 3);
        chk_st();
        press(9, P + 2);
        exp_st = mps_pkg::MPS_RUN;
        chk_st();
        chk_b("suspend_to_ram_n", 1'b1, suspend_to_ram_n);
        chk_b("carrier_reset_out_n", 1'b1, carrier_reset_out_n);
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk);
            alert_wakes <= (k == 3);
            press(2, P + 2);
            exp_st = mps_pkg::MPS_SUSPEND;
            chk_st();
            chk_b("suspend_to_ram_n", 1'b0, suspend_to_ram_n);
            chk_n("warning_first", 0, bad_fall);
            press(src[k], P + 2);
            exp_st = mps_pkg::MPS_RUN;
            chk_st();
        end
        @(posedge core_clk);
        alert_wakes <= 1'b0;
        s0 = evc[0];
        low_mask <= 10'h013;
        cyc(6);
        chk_b("battery_low", 1'b1, events.battery_low);
        chk_b("over_temp", 1'b1, events.over_temp);
        chk_b("mgmt_alert", 1'b1, events.mgmt_alert);
        chk_n("mgmt_smi", s0 + 1, evc[0]);
        @(posedge core_clk);
        low_mask <= 10'h000;
        cyc(6);
        chk_b("battery_low", 1'b0, events.battery_low);
        press(3, P - 3);
        chk_n("lid_change", 0, evc[6]);
        press(3, P + 2);
        chk_b("lid_change", 1'b1, evc[6] > 0);
        s0 = lo_cnt;
        @(posedge core_clk);
        low_mask[8] <= 1'b1;
        cyc(P + H + 8);
        chk_b("carrier_reset_out_n", 1'b1, carrier_reset_out_n);
        chk_b("reset_pulsed", 1'b1, lo_cnt > s0);
        chk_n("reset_press", 1, evc[7]);
        @(posedge core_clk);
        low_mask[8] <= 1'b0;
        cyc(6);
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk);
            cause <= 4'h1 << k;
            cyc(4);
            chk_b("carrier_reset_out_n", 1'b0, carrier_reset_out_n);
            @(posedge core_clk);
            cause <= 4'h0;
            cyc(H + 8);
            chk_b("carrier_reset_out_n", 1'b1, carrier_reset_out_n);
        end
        press(9, P + 2);
        exp_st = mps_pkg::MPS_SOFT_OFF;
        chk_st();
        chk_b("soft_off_n", 1'b0, soft_off_n);
        press(9, P + 2);
        exp_st = mps_pkg::MPS_RUN;
        chk_st();
        @(posedge core_clk);
        cpu_thermal_shutdown <= 1'b1;
        cyc(3);
        chk_b("thermal_trip_out_n", 1'b0, thermal_trip_out_n);
        exp_st = mps_pkg::MPS_SOFT_OFF;
        cyc(2);
        chk_st();
        chk_n("power_press", 3, evc[8]);
        chk_n("sleep_press", 5, evc[5]);
        chk_b("wake", 1'b1, evc[4] > 0);
        final_report;
    end
endmodule // mps_power_state_tb_top
`default_nettype wire
